/* File: rtl/phs_pcm_defines.vh */
// Constants for the PCM highway slot multiplexer
//==============================================================
// Contract
// R1 - Far side supplies the one highway line clock for both directions.
// R2 - Two select inputs decode: both low none, else highway channel 1..3.
// R3 - Each highway channel routes to a serial channel set by mode config.
// R4 - One-clock-prior: one-clock select pulse, following eight clocks form the slot.
// R5 - Envelope: select active over whole slot, any slot length allowed.
// R6 - Per-channel transmit request held until whole frame is sent.
// R7 - No transmit hold-off input; receiver runs whenever its enable is set.
// R8 - Serial channel gets no clock outside its slot, holds state.
// R9 - Rising select edge starts clocking and gives a sync pulse.
// R10 - No data means all-ones; once started one bit per slot clock.
// R11 - Receive data and clock reach a channel only during its slot.
// R12 - After request, next slot sends one all-ones byte then buffer bytes.
// R13 - Chained bytes without last flag go back to back, no fill.
// R14 - Request asserts a bounded number of line clocks after enable and data.
// R15 - First channel request has inverted polarity in highway mode.
// R16 - Received byte is written on the ninth slot clock after last bit.
// R17 - Reception starts with the first slot after receive enable; the receiver starts its bit count at the next slot clock, even mid-slot.
// R18 - Software sets transmit enable after falling select for fixed timing.
// R19 - Short slots get extra all-ones before data, delay stays fixed.
`ifndef PHS_PCM_DEFINES_VH
`define PHS_PCM_DEFINES_VH
//==============================================================
// Register indices
`define PHS_REG_MODE     4'h0
`define PHS_REG_CHCTRL   4'h1
`define PHS_REG_TXDATA0  4'h2
`define PHS_REG_RXDATA0  4'h5
`define PHS_REG_STATUS   4'h8
//==============================================================
// Field positions
`define PHS_MODE_HWY     0
`define PHS_MODE_ENV     1
`define PHS_MODE_ROUTE   2
`define PHS_CH_RXEN      4
`define PHS_LAST_BIT     8
`define PHS_ST_REQ       4
`define PHS_ST_RXV       8
//==============================================================
// Reset values and timing
`define PHS_MODE_RESET   8'he4
`define PHS_NO_CHAN      2'h3
`define PHS_SLOT_BITS    4'h8
`define PHS_RX_WRITE_DLY 4'h9
`define PHS_REQ_DELAY    6'h08
`endif

/* File: rtl/phs_pcm_highway_slot_mux.v */
// PCM highway slot multiplexer with three transparent serial channels
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "phs_pcm_defines.vh"

module phs_pcm_highway_slot_mux (
   input  wire        clk_sys,             // System clock, 40 MHz
   input  wire        rst_n,               // Async reset, active low
   input  wire        highway_line_clock,  // Highway line clock pin
   input  wire        slot_select_0,       // Sync select bit 0
   input  wire        slot_select_1,       // Sync select bit 1
   input  wire        highway_rx_data,     // Highway receive data
   output reg         highway_tx_data,     // Highway transmit data
   output reg  [2:0]  channel_tx_request,  // Per serial channel request
   input  wire [3:0]  reg_addr,            // Register index
   input  wire [15:0] reg_wdata,           // Write data
   input  wire        reg_wr,              // Write strobe
   input  wire        reg_rd,              // Read strobe
   output reg  [15:0] reg_rdata            // Read data, cycle after strobe
);

   localparam TX_IDLE = 3'h0;
   localparam TX_WAIT = 3'h1;
   localparam TX_ARM  = 3'h2;
   localparam TX_FILL = 3'h3;
   localparam TX_DATA = 3'h4;
   //==============================================================
   // Pin synchronisers
   reg  [3:0] sync_a;
   reg  [3:0] sync_b;
   reg  [3:0] sync_c;
   reg  [3:0] pin_filt;
   reg        lclk_prev;
   wire       lclk_rise;
   wire [1:0] sel_now;
   wire       rxd_now;
   // Three stages; a level is taken once the last two stages agree
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync_a    <= 4'h0;
         sync_b    <= 4'h0;
         sync_c    <= 4'h0;
         pin_filt  <= 4'h0;
         lclk_prev <= 1'b0;
      end else begin
         sync_a    <= {highway_rx_data, slot_select_1, slot_select_0, highway_line_clock};
         sync_b    <= sync_a;
         sync_c    <= sync_b;
         pin_filt  <= (sync_b & sync_c) | (pin_filt & (sync_b | sync_c));
         lclk_prev <= pin_filt[0];
      end
   end

   assign lclk_rise = pin_filt[0] & ~lclk_prev;   // [R1]
   assign sel_now   = pin_filt[2:1];
   assign rxd_now   = pin_filt[3];
   //==============================================================
   // Configuration registers
   reg  [7:0] mode_cfg;
   reg  [2:0] tx_en;
   reg  [2:0] rx_en;
   wire       hwy_mode = mode_cfg[`PHS_MODE_HWY];
   wire       env_mode = mode_cfg[`PHS_MODE_ENV];
   // Highway channel to serial channel lookup, 3 means unrouted
   function [1:0] route_of;
      input [1:0] hch;
      input [7:0] cfg;
      begin
         case (hch)
            2'h1:    route_of = cfg[`PHS_MODE_ROUTE +: 2];
            2'h2:    route_of = cfg[`PHS_MODE_ROUTE + 2 +: 2];
            2'h3:    route_of = cfg[`PHS_MODE_ROUTE + 4 +: 2];
            default: route_of = `PHS_NO_CHAN;
         endcase
      end
   endfunction
   //==============================================================
   // Slot timing
   reg  [1:0] prev_sel;
   reg  [1:0] ocp_ch;
   reg  [3:0] ocp_cnt;
   reg  [1:0] cur_ch;
   reg        slot_start;
   // Which highway channel owns this line clock, and is it the first
   always @* begin
      if (env_mode) begin
         cur_ch     = sel_now;                                   // [R5] [R2]
         slot_start = (sel_now != 2'h0) && (sel_now != prev_sel); // [R9]
      end else begin
         cur_ch     = (ocp_cnt != 4'h0) ? ocp_ch : 2'h0;         // [R4]
         slot_start = (ocp_cnt == `PHS_SLOT_BITS);               // [R9]
      end
   end

   // One-clock-prior pulse loads an eight clock slot
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prev_sel <= 2'h0;
         ocp_ch   <= 2'h0;
         ocp_cnt  <= 4'h0;
      end else if (lclk_rise) begin
         prev_sel <= sel_now;
         if (sel_now != 2'h0) begin
            ocp_ch  <= sel_now;                                  // [R4]
            ocp_cnt <= `PHS_SLOT_BITS;
         end else if (ocp_cnt != 4'h0) begin
            ocp_cnt <= ocp_cnt - 4'h1;
         end
      end
   end

   wire [1:0] svc      = route_of(cur_ch, mode_cfg);             // [R3]
   wire       slot_act = hwy_mode && (cur_ch != 2'h0) && (svc != `PHS_NO_CHAN);
   //==============================================================
   // Serial channels
   reg  [8:0] tx_hold   [0:2];
   reg  [2:0] tx_full;
   wire [2:0] tx_take;
   wire [2:0] tx_bit;
   wire [2:0] tx_req;
   wire [7:0] rx_word   [0:2];
   wire [2:0] rx_write;
   reg  [2:0] rx_valid;
   reg  [7:0] rx_data   [0:2];
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_ch
         wire       ch_clk  = lclk_rise && slot_act && (svc == gi);  // [R8] [R11]
         wire       ch_sync = ch_clk && slot_start;                  // [R9]
         reg  [2:0] st;
         reg  [5:0] dly;
         reg  [3:0] tbit;
         reg  [7:0] tsh;
         reg        tlast;
         reg        thave;
         reg        req;
         reg        take;
         reg  [7:0] rsh;
         reg  [7:0] rlag;
         reg  [2:0] rcnt;
         reg  [1:0] rdone;
         reg  [7:0] rcap;
         reg        rwr;

         // Transmit sequencer, clocked only by slot clocks once armed
         always @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               st    <= TX_IDLE;
               dly   <= 6'h00;
               tbit  <= 4'h0;
               tsh   <= 8'hff;
               tlast <= 1'b0;
               thave <= 1'b0;
               req   <= 1'b0;
               take  <= 1'b0;
            end else begin
               take <= 1'b0;
               if (!tx_en[gi] || !hwy_mode) begin
                  st    <= TX_IDLE;
                  req   <= 1'b0;
                  thave <= 1'b0;
               end else begin
                  case (st)
                     TX_IDLE: begin
                        if (tx_full[gi]) begin
                           dly <= 6'h00;
                           st  <= TX_WAIT;
                        end
                     end
                     TX_WAIT: begin
                        if (lclk_rise) begin
                           dly <= dly + 6'h01;
                           if (dly == `PHS_REQ_DELAY - 6'h01) begin
                              req <= 1'b1;                   // [R14] [R6]
                              st  <= TX_ARM;
                           end
                        end
                     end
                     TX_ARM: begin
                        // Fill byte only starts on a fresh slot edge
                        if (ch_sync) begin
                           tbit <= 4'h1;                     // [R12] [R19]
                           st   <= TX_FILL;
                        end
                     end
                     TX_FILL: begin
                        if (ch_clk) begin
                           if (tbit == `PHS_SLOT_BITS - 4'h1) begin
                              tsh   <= tx_hold[gi][7:0];
                              tlast <= tx_hold[gi][`PHS_LAST_BIT];
                              thave <= 1'b1;
                              take  <= 1'b1;
                              tbit  <= 4'h0;
                              st    <= TX_DATA;
                           end else begin
                              tbit <= tbit + 4'h1;
                           end
                        end
                     end
                     TX_DATA: begin
                        if (ch_clk) begin
                           if (thave) begin
                              tsh <= {1'b1, tsh[7:1]};       // [R10]
                           end
                           if (!thave || tbit == `PHS_SLOT_BITS - 4'h1) begin
                              tbit <= 4'h0;
                              if (tlast && thave) begin
                                 thave <= 1'b0;
                                 req   <= 1'b0;              // [R6]
                                 st    <= TX_IDLE;
                              end else if (tx_full[gi]) begin
                                 tsh   <= tx_hold[gi][7:0];  // [R13]
                                 tlast <= tx_hold[gi][`PHS_LAST_BIT];
                                 thave <= 1'b1;
                                 take  <= 1'b1;
                              end else begin
                                 thave <= 1'b0;              // [R10]
                              end
                           end else begin
                              tbit <= tbit + 4'h1;
                           end
                        end
                     end
                     default: st <= TX_IDLE;
                  endcase
               end
            end
         end
         assign tx_bit[gi]  = (st == TX_DATA && thave) ? tsh[0] : 1'b1;  // [R10]
         assign tx_req[gi]  = req;
         assign tx_take[gi] = take;
         // Receive shifter; ninth clock after a byte is one past the next byte's end
         always @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               rsh   <= 8'h00;
               rlag  <= 8'h00;
               rcnt  <= 3'h0;
               rdone <= 2'h0;
               rcap  <= 8'h00;
               rwr   <= 1'b0;
            end else begin
               rwr <= 1'b0;
               if (!rx_en[gi]) begin
                  rcnt  <= 3'h0;                             // [R17]
                  rdone <= 2'h0;
               end else if (ch_clk) begin                    // [R7] [R11]
                  rsh   <= {rxd_now, rsh[7:1]};
                  rlag  <= {rsh[0], rlag[7:1]};              // Older byte waits here
                  rcnt  <= rcnt + 3'h1;
                  rdone <= rdone + {1'b0, (rcnt == 3'h7) && (rdone != 2'h2)};
                  if (rcnt == 3'h0 && rdone == 2'h2) begin
                     rcap <= rlag;                           // [R16]
                     rwr  <= 1'b1;
                  end
               end
            end
         end
         assign rx_word[gi]  = rcap;
         assign rx_write[gi] = rwr;
      end
   endgenerate
   //==============================================================
   // Highway outputs
   // Unowned clocks and unrouted slots idle high
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         highway_tx_data    <= 1'b1;
         channel_tx_request <= 3'h7;
      end else begin
         if (lclk_rise) begin
            highway_tx_data <= slot_act ? tx_bit[svc] : 1'b1;
         end
         channel_tx_request[0] <= ~hwy_mode | tx_req[0];     // [R15]
         channel_tx_request[2:1] <= ~tx_req[2:1];
      end
   end

   //==============================================================
   // Register port
   wire       wr_tx  = reg_wr && (reg_addr >= `PHS_REG_TXDATA0) && (reg_addr < `PHS_REG_RXDATA0);
   wire [3:0] wr_idx = reg_addr - `PHS_REG_TXDATA0;
   wire [3:0] rd_idx = reg_addr - `PHS_REG_RXDATA0;
   wire       rd_rx  = reg_rd && (reg_addr >= `PHS_REG_RXDATA0) && (reg_addr < `PHS_REG_STATUS);
   integer k;
   // Writes, holding bytes and receive flags; hardware set beats read clear
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mode_cfg <= `PHS_MODE_RESET;
         tx_en    <= 3'h0;
         rx_en    <= 3'h0;
         tx_full  <= 3'h0;
         rx_valid <= 3'h0;
         for (k = 0; k < 3; k = k + 1) begin
            tx_hold[k] <= 9'h000;
            rx_data[k] <= 8'h00;
         end
      end else begin
         if (reg_wr && reg_addr == `PHS_REG_MODE) begin
            mode_cfg <= reg_wdata[7:0];
         end
         if (reg_wr && reg_addr == `PHS_REG_CHCTRL) begin
            tx_en <= reg_wdata[2:0];                         // [R18]
            rx_en <= reg_wdata[`PHS_CH_RXEN +: 3];
         end
         for (k = 0; k < 3; k = k + 1) begin
            if (tx_take[k]) begin
               tx_full[k] <= 1'b0;
            end else if (wr_tx && wr_idx == k && !tx_full[k]) begin
               tx_hold[k] <= reg_wdata[8:0];
               tx_full[k] <= 1'b1;
            end
            if (rx_write[k]) begin
               rx_data[k]  <= rx_word[k];
               rx_valid[k] <= 1'b1;
            end else if (rd_rx && rd_idx == k) begin
               rx_valid[k] <= 1'b0;
            end
         end
      end
   end

   // Read data, valid only in the cycle after the strobe
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `PHS_REG_MODE:   reg_rdata <= {8'h00, mode_cfg};
            `PHS_REG_CHCTRL: reg_rdata <= {9'h000, rx_en, 1'b0, tx_en};
            4'h2, 4'h3, 4'h4: reg_rdata <= {7'h00, tx_hold[wr_idx[1:0]]};
            4'h5, 4'h6, 4'h7: reg_rdata <= {7'h00, rx_valid[rd_idx[1:0]], rx_data[rd_idx[1:0]]};
            `PHS_REG_STATUS: reg_rdata <= {5'h00, rx_valid, 1'b0, tx_req, 1'b0, tx_full};
            default:         reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

endmodule

/* File: testbench/phs_slot_mux_properties.sv */
// Port checks for the PCM highway slot multiplexer
`timescale 1ns/1ps

module phs_slot_mux_properties (
   input wire        clk_sys,            // System clock
   input wire        rst_n,              // Reset, active low
   input wire        slot_select_0,      // Select bit 0
   input wire        slot_select_1,      // Select bit 1
   input wire        highway_tx_data,    // Line data out
   input wire [2:0]  channel_tx_request, // Requests
   input wire [3:0]  reg_addr,           // Index
   input wire [15:0] reg_wdata,          // Write data
   input wire        reg_wr,             // Write strobe
   input wire        reg_rd,             // Read strobe
   input wire [15:0] reg_rdata           // Read data
);
   reg [7:0] mode_q;  // Mode shadow
   reg [2:0] txen_q;  // Tx enable shadow
   reg [3:0] quiet_n; // Cycles with no transmitter allowed
   reg [3:0] gap_n;   // Envelope cycles without select
   //==========================================================
   // Shadows and saturating counters; 12 cycles outlast one line bit
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= 8'he4;
         txen_q <= 3'h0;
         quiet_n <= 4'h0;
         gap_n <= 4'h0;
      end else begin
         if (reg_wr && reg_addr == 4'h0)
            mode_q <= reg_wdata[7:0];
         if (reg_wr && reg_addr == 4'h1)
            txen_q <= reg_wdata[2:0];
         if (!mode_q[0] || txen_q == 3'h0)
            quiet_n <= (quiet_n == 4'hf) ? quiet_n : quiet_n + 4'h1;
         else
            quiet_n <= 4'h0;
         if (mode_q[1:0] == 2'h3 && !slot_select_0 && !slot_select_1)
            gap_n <= (gap_n == 4'hf) ? gap_n : gap_n + 4'h1;
         else
            gap_n <= 4'h0;
      end
   end
   //==========================================================
   // Properties
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_mode_read;
      reg_rd && reg_addr == 4'h0;
   endsequence
   sequence s_req_held;
      channel_tx_request[0] [*8];
   endsequence
   property p_rd_zero;
      !$past(reg_rd) |-> reg_rdata == 16'h0000;
   endproperty
   property p_mode_rd;
      s_mode_read |=> reg_rdata == {8'h00, mode_q};
   endproperty
   property p_unmapped;
      reg_rd && reg_addr > 4'h8 |=> reg_rdata == 16'h0000;
   endproperty
   property p_hwy_off_req;
      !mode_q[0] && !$past(mode_q[0]) |-> channel_tx_request[0];
   endproperty
   property p_txoff_req;
      txen_q == 3'h0 && $past(txen_q) == 3'h0 && $past(txen_q, 2) == 3'h0 && $stable(mode_q)
         |-> channel_tx_request == {2'h3, ~mode_q[0]};
   endproperty
   property p_req_held;
      $rose(channel_tx_request[0]) && mode_q[0] |-> s_req_held;
   endproperty
   property p_quiet_tx;
      quiet_n >= 4'hc |-> highway_tx_data;
   endproperty
   property p_env_gap_tx;
      gap_n >= 4'hc |-> highway_tx_data;
   endproperty
   a_rd_zero: assert property (p_rd_zero)
      else $error("read data not zero outside read cycle");
   a_mode_rd: assert property (p_mode_rd)
      else $error("mode readback wrong");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   a_hwy_off_req: assert property (p_hwy_off_req)
      else $error("first request low outside highway mode");
   a_txoff_req: assert property (p_txoff_req)
      else $error("request active with transmitters off");
   a_req_held: assert property (p_req_held)
      else $error("request dropped too soon");
   a_quiet_tx: assert property (p_quiet_tx)
      else $error("line data not ones while no transmitter runs");
   a_env_gap_tx: assert property (p_env_gap_tx)
      else $error("line data not ones between envelope slots");
endmodule

bind phs_pcm_highway_slot_mux phs_slot_mux_properties i_chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .slot_select_0(slot_select_0),
   .slot_select_1(slot_select_1), .highway_tx_data(highway_tx_data),
   .channel_tx_request(channel_tx_request), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

/* File: testbench/phs_highway_partner.sv */
// Model of the highway timing logic and the far slot device
`timescale 1ns/1ps

module phs_highway_partner (
   output reg         line_clk, // Free-running line clock
   output reg         sel0,     // Select bit 0
   output reg         sel1,     // Select bit 1
   output reg         rx_d,     // Data toward the block
   input  wire        tx_d,     // Data from the block
   input  wire        env,      // 1 envelope, 0 one-clock-prior
   input  wire [7:0]  rx_byte,  // Byte sent in each slot, LSB first
   output reg  [7:0]  cap,      // Byte taken from the last slot
   output reg  [15:0] nslot     // Completed slots
);
   integer pos;
   integer nxt;
   //==========================================================
   // Frame of 12 clocks, slot bits at 1..8; inputs move 50 ns before a
   // rise so the block's late filtered edge still sees them held
   initial begin
      line_clk = 1'b0;
      {sel1, sel0} = 2'h0;
      rx_d = 1'b1;
      cap = 8'h00;
      nslot = 16'h0000;
      pos = 0;
      forever begin
         #50;
         nxt = (pos + 1) % 12;
         if (env ? (nxt >= 1 && nxt <= 8) : (nxt == 0))
            {sel1, sel0} = 2'h1;
         else
            {sel1, sel0} = 2'h0;
         if (nxt >= 1 && nxt <= 8)
            rx_d = rx_byte[nxt-1];
         else
            rx_d = ~rx_d; // Released line, never a steady value
         #45;
         if (pos >= 1 && pos <= 8)
            cap[pos-1] = tx_d;
         if (pos == 8)
            nslot = nslot + 16'h0001;
         #5 line_clk = 1'b1; // One clock for both directions
         pos = nxt;
         #100 line_clk = 1'b0;
      end
   end
endmodule

/* File: testbench/test_pcm_highway_slot_mux.sv */
// Self-checking bench for the PCM highway slot multiplexer
`timescale 1ns/1ps

module test_pcm_highway_slot_mux;
   reg         clk_sys;   // 40 MHz
   reg         rst_n;     // Reset, active low
   reg  [3:0]  reg_addr;  // Index
   reg  [15:0] reg_wdata; // Write data
   reg         reg_wr;    // Write strobe
   reg         reg_rd;    // Read strobe
   reg         env;       // Partner sync mode
   reg  [7:0]  rx_byte;   // Partner slot byte
   reg  [15:0] rdv;       // Last read value
   wire [15:0] reg_rdata;
   wire [2:0]  req;
   wire [7:0]  cap;
   wire [15:0] nslot;
   wire        line_clk;
   wire        sel0;
   wire        sel1;
   wire        rx_d;
   wire        tx_d;
   integer     err_total;
   integer     n_tests;
   integer     want;
   integer     k;
   integer     cyc;

   phs_pcm_highway_slot_mux i_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .highway_line_clock(line_clk),
      .slot_select_0(sel0), .slot_select_1(sel1), .highway_rx_data(rx_d),
      .highway_tx_data(tx_d), .channel_tx_request(req), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   phs_highway_partner i_far (
      .line_clk(line_clk), .sel0(sel0), .sel1(sel1), .rx_d(rx_d), .tx_d(tx_d),
      .env(env), .rx_byte(rx_byte), .cap(cap), .nslot(nslot));

   //==========================================================
   // Clock and hang guard
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         wrap_up;
      end
   end
   //==========================================================
   // Bus and check tasks
   task chk(input [15:0] got, input [15:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task wr(input [3:0] a, input [15:0] d);
      begin
         @(posedge clk_sys);
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge clk_sys);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input [3:0] a);
      begin
         @(posedge clk_sys);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge clk_sys);
         reg_rd <= 1'b0;
         #1 rdv = reg_rdata;
      end
   endtask
   task next_slot;
      begin
         want = want + 1;
         for (k = 0; k < 300 && nslot < want; k = k + 1)
            @(posedge clk_sys);
      end
   endtask
   task wrap_up;
      begin
         if (err_total == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   //==========================================================
   // One frame on channel 0: setup in a gap, then slot by slot
   task run(input [7:0] m, input [7:0] b0, input [7:0] b1, input [7:0] rb);
      begin
         want = nslot;
         next_slot;
         wr(4'h1, 16'h0000);
         rd(4'h5); // Drops a stale received byte
         wr(4'h0, {8'h00, m});
         env <= m[1];
         rx_byte <= rb;
         wr(4'h2, {8'h00, b0});
         wr(4'h1, 16'h0011);
         chk({13'h0000, req}, 16'h0006);
         for (k = 0; k < 300 && req[0] !== 1'b1; k = k + 1)
            @(posedge clk_sys);
         chk({15'h0000, req[0]}, 16'h0001);
         next_slot;
         chk({8'h00, cap}, 16'h00ff);
         rd(4'h5);
         chk({15'h0000, rdv[8]}, 16'h0000);
         next_slot;
         chk({8'h00, cap}, 16'h00ff);
         rd(4'h5);
         chk({15'h0000, rdv[8]}, 16'h0000);
         rd(4'h8);
         for (k = 0; k < 60 && rdv[0] !== 1'b0; k = k + 1)
            rd(4'h8);
         wr(4'h2, {8'h01, b1});
         next_slot;
         chk({8'h00, cap}, {8'h00, b0});
         rd(4'h5);
         chk(rdv, {8'h01, rb});
         next_slot;
         chk({8'h00, cap}, {8'h00, b1});
         chk({15'h0000, req[0]}, 16'h0000);
         next_slot;
         chk({8'h00, cap}, 16'h00ff);
      end
   endtask
   //==========================================================
   // Main sequence
   initial begin
      rst_n = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      env = 1'b0;
      rx_byte = 8'h00;
      rdv = 16'h0000;
      err_total = 0;
      n_tests = 0;
      want = 0;
      cyc = 0;
      repeat (20) @(posedge clk_sys);
      chk({13'h0000, req}, 16'h0007);
      chk({15'h0000, tx_d}, 16'h0001);
      rst_n <= 1'b1;
      wr(4'hf, 16'hffff);
      rd(4'h0);
      chk(rdv, 16'h00e4);
      rd(4'hf);
      chk(rdv, 16'h0000);
      run(8'he1, 8'h3c, 8'ha5, 8'h5a);
      run(8'he3, 8'h96, 8'h0f, 8'hc3);
      wrap_up;
   end
endmodule
